/* rtl/cpca_pkg.sv */
// Package with types and constants of the current and power calculation engine.
package cpca_pkg;

   localparam int            SAMPLE_W   = 16;
   localparam int            CAL_W      = 15;
   localparam int            CUR_W      = 32;
   localparam int            PWR_W      = 48;
   localparam int            ACC_EXT_W  = 11;
   localparam int            AVG_W      = 11;
   localparam logic [10:0]   AVG_MAX    = 11'h400;
   localparam logic [10:0]   AVG_ONE    = 11'h001;
   localparam logic [10:0]   AVG_RST    = 11'h001;
   localparam int            DIV_STEPS  = 59;
   localparam logic [5:0]    DIV_CNT_RST = 6'h00;

   // Channel select of the shared converter.
   typedef enum logic [1:0]
   {
      CPCA_CH_SHUNT = 2'h0,
      CPCA_CH_BUS   = 2'h1,
      CPCA_CH_TEMP  = 2'h2
   } cpca_chan_e;

   // One converted sample as delivered by the conversion sequencer.
   typedef struct packed
   {
      logic                  valid;
      cpca_chan_e            chan;
      logic [SAMPLE_W-1:0]   data;
   } cpca_sample_s;

   // Configuration seen by the engine.
   typedef struct packed
   {
      logic                  continuous;
      logic                  trigger;
      logic [AVG_W-1:0]      avg_count;
      logic [CAL_W-1:0]      shunt_cal;
   } cpca_cfg_s;

   typedef enum logic [4:0]
   {
      CPCA_IDLE  = 5'b00001,
      CPCA_RUN   = 5'b00010,
      CPCA_DIVC  = 5'b00100,
      CPCA_DIVP  = 5'b01000,
      CPCA_DONE  = 5'b10000
   } cpca_state_e;

endpackage : cpca_pkg

/* rtl/cpca_divider.sv */
// Serial restoring divider that turns an accumulated sum into an average.
`timescale 1ns/10ps
module cpca_divider
   import cpca_pkg::*;
(
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // Request
   input  wire logic                 start,
   input  wire logic signed [58:0]   dividend,
   input  wire logic [AVG_W-1:0]     divisor,
   // Result
   output logic                      done,
   output logic signed [58:0]        quotient
);

   typedef struct packed
   {
      logic          busy;
      logic          done;
      logic          neg;
      logic [5:0]    cnt;
      logic [58:0]   rem;
      logic [58:0]   quo;
      logic [58:0]   q_out;
   } cpca_div_s;

   cpca_div_s st_r;
   cpca_div_s st_nxt;

   always_comb
   begin
      logic [59:0] trial;
      trial  = '0;
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      if (start)
      begin
         st_nxt.busy = 1'b1;
         st_nxt.neg  = dividend[58];
         st_nxt.quo  = dividend[58] ? 59'(-dividend) : dividend;
         st_nxt.rem  = '0;
         st_nxt.cnt  = DIV_CNT_RST;
      end
      else if (st_r.busy)
      begin
         trial = {st_r.rem, st_r.quo[58]} - {49'h0, divisor};
         if (!trial[59])
         begin
            st_nxt.rem = trial[58:0];
            st_nxt.quo = {st_r.quo[57:0], 1'b1};
         end
         else
         begin
            st_nxt.rem = {st_r.rem[57:0], st_r.quo[58]};
            st_nxt.quo = {st_r.quo[57:0], 1'b0};
         end
         st_nxt.cnt = st_r.cnt + 6'h01;
         if (st_r.cnt == 6'(DIV_STEPS - 1))
         begin
            st_nxt.busy  = 1'b0;
            st_nxt.done  = 1'b1;
            st_nxt.q_out = st_r.neg ? 59'(-st_nxt.quo) : st_nxt.quo;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign done     = st_r.done;
   assign quotient = st_r.q_out;

endmodule : cpca_divider

/* rtl/cpca_engine.sv */
// Background current and power calculation engine with averaging accumulator.
// Functional notes
// - New current and power after shunt+bus pair.
// - Power uses previous current times newest bus.
// - Zero shunt calibration forces zero power.
// - Averaging above one accumulates intermediate results.
// - Load outputs only after full averaging set.
// - Arithmetic runs beside conversions, never stalls them.
// - Samples arrive one multiplexed channel at a time.
// - Continuous and triggered single-pass modes supported.
// - Averaging count programmable one to 1024.
// - Outputs hold until next completed average.
`timescale 1ns/10ps
module cpca_engine
   import cpca_pkg::*;
(
   // Clock and reset
   input  wire logic                 REF_CLK,
   input  wire logic                 RSTN,
   // Sample stream from the conversion sequencer
   input  wire cpca_sample_s         SAMPLE,
   // Configuration
   input  wire cpca_cfg_s            CFG,
   // Results
   output logic signed [CUR_W-1:0]   CURRENT,
   output logic [PWR_W-1:0]          POWER,
   output logic                      RESULT_READY,
   output logic                      BUSY
);

   typedef struct packed
   {
      cpca_state_e                state;
      logic                       have_shunt;
      logic                       have_cur;
      logic signed [CUR_W-1:0]    cur_last;
      logic [SAMPLE_W-1:0]        bus_last;
      logic [AVG_W-1:0]           avg_cnt;
      logic [AVG_W-1:0]           avg_done;
      logic signed [58:0]         acc_cur;
      logic signed [58:0]         acc_pwr;
      logic                       div_go;
      logic signed [CUR_W-1:0]    cur_out;
      logic [PWR_W-1:0]           pwr_out;
      logic                       ready;
      logic                       busy;
   } cpca_st_s;

   cpca_st_s            st_r;
   cpca_st_s            st_nxt;
   logic                div_done;
   logic signed [58:0]  div_q;
   logic signed [58:0]  div_in;

   // The dividend follows the state, so the power sum reaches the divider only
   // after the current average has been taken.
   assign div_in = (st_r.state == CPCA_DIVP) ? st_r.acc_pwr : st_r.acc_cur;

   cpca_divider u_div
   (
      .clk      (REF_CLK),
      .rst_n    (RSTN),
      .start    (st_r.div_go),
      .dividend (div_in),
      .divisor  (st_r.avg_cnt),
      .done     (div_done),
      .quotient (div_q)
   );

   always_comb
   begin
      logic signed [CUR_W-1:0] cur_new;
      logic [PWR_W-1:0]        pwr_new;
      logic                    pair;
      logic [AVG_W-1:0]        cnt_cfg;
      logic [CUR_W-1:0]        cur_mag;
      logic                    set_full;
      cur_new  = '0;
      pwr_new  = '0;
      pair     = 1'b0;
      cur_mag  = '0;
      set_full = 1'b0;
      cnt_cfg  = CFG.avg_count;
      // A count of zero or above the largest set cannot be honoured, so it
      // falls back to a single conversion instead of stalling the pass.
      if (cnt_cfg == 11'h000 || cnt_cfg > AVG_MAX)
         cnt_cfg = AVG_ONE;
      st_nxt = st_r;
      st_nxt.div_go = 1'b0;
      // The engine never back-pressures the sequencer; samples are taken only in the run state.
      if (SAMPLE.valid && st_r.state == CPCA_RUN)
      begin
         case (SAMPLE.chan)
            CPCA_CH_SHUNT:
            begin
               // No LSB scaling is applied: the current is sample times calibration.
               cur_new = CUR_W'($signed(SAMPLE.data) * $signed({1'b0, CFG.shunt_cal}));
               st_nxt.cur_last   = cur_new;
               st_nxt.have_shunt = 1'b1;
               st_nxt.have_cur   = 1'b1;
            end
            CPCA_CH_BUS:
            begin
               st_nxt.bus_last = SAMPLE.data;
               pair = st_r.have_shunt;
            end
            default:
            begin
               // Temperature has no part in current or power, and a pending shunt
               // sample must survive it so that the pair is not broken.
               st_nxt.have_shunt = st_r.have_shunt;
            end
         endcase
      end
      if (pair)
      begin
         // Previous current only, so a later shunt sample cannot leak in.
         // Power is reported as a magnitude, so the current is folded first.
         if (st_r.cur_last[CUR_W-1])
            cur_mag = $unsigned(-st_r.cur_last);
         else
            cur_mag = $unsigned(st_r.cur_last);
         if (CFG.shunt_cal != '0 && st_r.have_cur)
            pwr_new = PWR_W'(cur_mag * SAMPLE.data);
         else
            pwr_new = '0;
         st_nxt.have_shunt = 1'b0;
         // The sums are sized for a full set of 1024 extreme samples, so the
         // accumulator can never wrap before the divide.
         st_nxt.acc_cur  = st_r.acc_cur + 59'(st_r.cur_last);
         st_nxt.acc_pwr  = st_r.acc_pwr + 59'(pwr_new);
         st_nxt.avg_done = st_r.avg_done + 11'h001;
         set_full        = (st_r.avg_done + 11'h001) >= st_r.avg_cnt;
         if (set_full)
         begin
            st_nxt.state  = CPCA_DIVC;
            st_nxt.div_go = 1'b1;
         end
      end
      case (st_r.state)
         CPCA_IDLE:
         begin
            if (CFG.continuous || CFG.trigger)
            begin
               st_nxt.state    = CPCA_RUN;
               st_nxt.avg_cnt  = cnt_cfg;
               st_nxt.avg_done = '0;
               st_nxt.acc_cur  = '0;
               st_nxt.acc_pwr  = '0;
               // Ready drops only when a fresh pass starts from idle, so a
               // free-running engine keeps it set between sets.
               st_nxt.ready    = 1'b0;
               st_nxt.have_shunt = 1'b0;
            end
         end
         CPCA_RUN:
         begin
            // Samples are taken above; the pass leaves this state only when the
            // set is full, so the sequencer never waits on the arithmetic.
            st_nxt.state = st_nxt.state;
         end
         // One serial divider serves both averages in turn; it costs some
         // sixty cycles each but saves a second wide divider.
         CPCA_DIVC:
         begin
            if (div_done)
            begin
               st_nxt.cur_out = CUR_W'(div_q);
               st_nxt.state   = CPCA_DIVP;
               st_nxt.div_go  = 1'b1;
            end
         end
         CPCA_DIVP:
         begin
            if (div_done)
            begin
               // Ready rises with the power word, the later of the two loads; a pass that does not start
               // from idle keeps ready set, so the new current is seen beside the old power.
               st_nxt.pwr_out = PWR_W'(div_q);
               st_nxt.ready   = 1'b1;
               st_nxt.state   = CPCA_DONE;
            end
         end
         CPCA_DONE:
         begin
            // Triggered mode returns to idle from here until the next trigger request.
            st_nxt.avg_done = '0;
            st_nxt.acc_cur  = '0;
            st_nxt.acc_pwr  = '0;
            st_nxt.avg_cnt  = cnt_cfg;
            st_nxt.have_shunt = 1'b0;
            if (CFG.continuous || CFG.trigger)
               st_nxt.state = CPCA_RUN;
            else
               st_nxt.state = CPCA_IDLE;
         end
         default:
            st_nxt.state = CPCA_IDLE;
      endcase
      // Busy is registered beside the state so that the output leaves a flip-flop.
      st_nxt.busy = (st_nxt.state != CPCA_IDLE);
   end

   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         st_r         <= '0;
         st_r.state   <= CPCA_IDLE;
         // The count resets to one; the first pass still loads the configured count when it leaves idle.
         st_r.avg_cnt <= AVG_RST;
      end
      else
         st_r <= st_nxt;
   end

   assign CURRENT      = st_r.cur_out;
   assign POWER        = st_r.pwr_out;
   assign RESULT_READY = st_r.ready;
   assign BUSY         = st_r.busy;

endmodule : cpca_engine

/* verif/cpca_engine_chk.sv */
// Assertion checker of the current and power calculation engine.
`timescale 1ns/10ps
module cpca_engine_chk
   import cpca_pkg::*;
(
   // Clock and reset
   input wire logic                    REF_CLK,
   input wire logic                    RSTN,
   // Stimulus
   input wire cpca_sample_s            SAMPLE,
   input wire cpca_cfg_s               CFG,
   // Results
   input wire logic signed [CUR_W-1:0] CURRENT,
   input wire logic [PWR_W-1:0]        POWER,
   input wire logic                    RESULT_READY,
   input wire logic                    BUSY
);
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RSTN);

   cur_idle_hold_a: assert property (!BUSY |=> $stable(CURRENT))
      else $error("current moved while idle");
   pwr_with_ready_a: assert property ($changed(POWER) |-> RESULT_READY)
      else $error("power loaded without ready");
   ready_in_pass_a: assert property ($rose(RESULT_READY) |-> BUSY)
      else $error("ready rose outside a pass");
   zero_cal_pwr_a: assert property ($rose(RESULT_READY) && CFG.shunt_cal == 15'h0
      |-> POWER == 48'h0) else $error("power not zero with zero calibration");
   ready_clear_a: assert property ($fell(RESULT_READY) |-> BUSY)
      else $error("ready cleared outside a pass");
   ready_keep_a: assert property (RESULT_READY && !BUSY && !CFG.trigger && !CFG.continuous
      |=> RESULT_READY)
      else $error("ready lost while idle");
   idle_stay_a: assert property (!BUSY && !CFG.trigger && !CFG.continuous |=> !BUSY)
      else $error("pass started without request");
   idle_start_a: assert property (!BUSY && CFG.trigger |=> BUSY)
      else $error("trigger did not start a pass");

   cover property ($rose(RESULT_READY));
   cover property ($rose(RESULT_READY) && CFG.shunt_cal == 15'h0);
   cover property (BUSY && CFG.continuous && SAMPLE.valid);
endmodule : cpca_engine_chk

bind cpca_engine cpca_engine_chk chk_u (.REF_CLK(REF_CLK), .RSTN(RSTN), .SAMPLE(SAMPLE),
   .CFG(CFG), .CURRENT(CURRENT), .POWER(POWER), .RESULT_READY(RESULT_READY), .BUSY(BUSY));

/* verif/testbench.sv */
// Self-checking testbench of the current and power calculation engine.
`timescale 1ns/10ps
module testbench
   import cpca_pkg::*;
   ;
   logic                    ref_clk;
   logic                    rstn;
   cpca_sample_s            sample;
   cpca_cfg_s               cfg;
   logic signed [CUR_W-1:0] current;
   logic [PWR_W-1:0]        power;
   logic                    rdy;
   logic                    busy;
   int                      n_fail;
   int                      check_count;
   int                      np;
   longint                  sc;
   longint                  sp;
   longint                  oc;
   longint                  op;

   cpca_engine dut_u (.REF_CLK(ref_clk), .RSTN(rstn), .SAMPLE(sample), .CFG(cfg),
      .CURRENT(current), .POWER(power), .RESULT_READY(rdy), .BUSY(busy));

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Snapshot of the last average, so held outputs can be judged.
   task automatic snap();
      oc = sc / np;
      op = sp / np;
      sc = 0;
      sp = 0;
      np = 0;
   endtask : snap

   task automatic begin_pass(input logic [10:0] avg, input logic [14:0] cal, input logic cont);
      snap();
      cfg = '{cont, 1'b1, avg, cal};
      tick(1);
      cfg.trigger = 1'b0;
      tick(1);
   endtask : begin_pass

   // Data is scrambled after the strobe so stale values never look valid.
   task automatic send(input cpca_chan_e ch, input logic [15:0] d);
      sample = '{1'b1, ch, d};
      tick(1);
      sample = '{1'b0, ch, ~d};
      tick(1);
   endtask : send

   task automatic pair(input logic signed [15:0] s, input logic [15:0] b);
      longint ci;
      ci = longint'(s) * longint'(cfg.shunt_cal);
      sc += ci;
      sp += (ci < 0 ? -ci : ci) * longint'(b);
      np++;
      send(CPCA_CH_SHUNT, s);
      send(CPCA_CH_BUS, b);
   endtask : pair

   // The engine needs over 120 cycles after the last pair of a set.
   task automatic expect_avg();
      tick(140);
      chk(rdy, 64'h1);
      chk(current, sc / np);
      chk(power, sp / np);
   endtask : expect_avg

   task automatic t_single();
      begin_pass(11'h000, 15'h0003, 1'b0);
      pair(16'hff9c, 16'h01f4);
      expect_avg();
   endtask : t_single

   task automatic t_avg();
      begin_pass(11'h004, 15'h1234, 1'b0);
      pair(16'h7fff, 16'hffff);
      send(CPCA_CH_TEMP, 16'h0bad);
      pair(16'hfffb, 16'h0003);
      tick(140);
      chk(current, oc);
      chk(power, op);
      pair(16'h8000, 16'h0002);
      pair(16'h03e8, 16'h7777);
      expect_avg();
   endtask : t_avg

   task automatic t_zero();
      begin_pass(11'h003, 15'h0000, 1'b0);
      pair(16'h04d2, 16'h03e7);
      pair(16'hfff9, 16'hffff);
      // Calibration drops to zero between shunt and bus, so current is not zero.
      cfg.shunt_cal = 15'h0011;
      send(CPCA_CH_SHUNT, 16'h0064);
      cfg.shunt_cal = 15'h0000;
      send(CPCA_CH_BUS, 16'h03e7);
      sc += 1700;
      np++;
      expect_avg();
   endtask : t_zero

   task automatic t_max();
      begin_pass(AVG_MAX, 15'h0002, 1'b0);
      repeat (1023) pair(16'h0007, 16'h000a);
      tick(140);
      chk(current, oc);
      pair(16'h0007, 16'h000a);
      expect_avg();
   endtask : t_max

   task automatic t_cont();
      begin_pass(11'h001, 15'h0009, 1'b1);
      pair(16'h0014, 16'h001e);
      expect_avg();
      snap();
      pair(16'hffd8, 16'h0032);
      expect_avg();
   endtask : t_cont

   task automatic finish_test();
      if (n_fail == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : finish_test

   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   initial
   begin
      n_fail = 0;
      check_count = 0;
      np = 1;
      sc = 0;
      sp = 0;
      cfg = '0;
      sample = '0;
      rstn = 1'b0;
      tick(4);
      rstn = 1'b1;
      tick(1);
      t_single();
      t_avg();
      t_zero();
      t_max();
      t_cont();
      finish_test();
   end

   // The whole run needs under 8000 cycles; this cuts a hang short.
   initial
   begin
      #(20000 * 100);
      n_fail++;
      finish_test();
   end
endmodule : testbench
